// ### hw/hmp_pkg.sv
/*
  shared constants and carrier types of the host memory port.
  assumes a single core clock; times in core clock periods unless given in ns or half clock periods.
*/
`default_nettype none
package hmp_pkg;
  // -----------------------------------------------------------------
  // timing
  // -----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  localparam int PIN_EVENT_NS = 10;
  // least ack-high time after start, counted in half clock periods
  localparam int ACK_LOW_MIN_HALF_CK = 3;
  localparam int ACK_LOW_MIN_CYC = (ACK_LOW_MIN_HALF_CK + 1) / 2;
  // previous read data hold, counted in clock periods
  localparam int PREV_HOLD_DM_PM1_CK = 2;
  localparam int PREV_HOLD_PM2_CK = 1;
  localparam int CNT_W = 2;
  localparam int SYNC_STAGES = 2;

  // -----------------------------------------------------------------
  // address map and overlay register
  // -----------------------------------------------------------------
  localparam int ADDR_W = 15;
  localparam int DM_SEL_BIT = 15;
  localparam logic [14:0] OVL_ADDR = 15'h3fe7;
  localparam int OVL_SROM_BIT = 14;
  localparam logic [15:0] OVL_RESET = 16'h0000;
  localparam logic [15:0] BUS_RESET = 16'h0000;
  localparam int PM_W = 24;
  localparam int PM_LO_W = 8;

  // -----------------------------------------------------------------
  // types
  // -----------------------------------------------------------------
  typedef struct packed {
    logic sel_n;
    logic wr_n;
    logic rd_n;
    logic al;
    logic [15:0] bus;
  } hmp_pins_t;

  typedef struct packed {
    logic pm;
    logic [14:0] addr;
    logic [23:0] data;
  } hmp_wr_t;

  localparam int WR_W = $bits(hmp_wr_t);

  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_WRITE = 3'h1,
    ST_WDONE = 3'h3,
    ST_READ  = 3'h2,
    ST_RFIN  = 3'h6
  } hmp_state_t;
endpackage
`default_nettype wire

// ### hw/hmp_fifo.sv
/*
  write fifo of the host memory port with registered output stage.
  assumes in_ready is sampled by the filling side in the same cycle.
*/
`default_nettype none
`timescale 1ns/100ps
module hmp_fifo #(
  parameter int WIDTH = 40,
  parameter int DEPTH = 16
) (
  input wire logic core_clk, // core clock
  input wire logic rst_n, // async reset, active low
  input wire logic ce, // clock enable
  input wire logic in_valid, // push request
  output logic in_ready, // space available
  input wire logic [WIDTH-1:0] in_data, // pushed word
  output logic out_valid, // head word valid
  input wire logic out_ready, // drain side takes head
  output logic [WIDTH-1:0] out_data, // head word
  output logic empty // nothing stored at all
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PW-1:0] wp_q;
  logic [PW-1:0] rp_q;
  logic [CW-1:0] cnt_q;
  logic ov_q;
  logic [WIDTH-1:0] od_q;
  logic push;
  logic load;

  assign in_ready = (cnt_q != CW'(DEPTH));
  assign push = in_valid && in_ready;
  assign load = (cnt_q != '0) && (!ov_q || out_ready);
  assign out_valid = ov_q;
  assign out_data = od_q;
  assign empty = (cnt_q == '0) && !ov_q;

  always_ff @(posedge core_clk) begin
    if (ce && push) begin
      mem_q[wp_q] <= in_data;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end else if (ce) begin
      if (push) begin
        wp_q <= (wp_q == PW'(DEPTH - 1)) ? '0 : wp_q + 1'b1;
      end
      if (load) begin
        rp_q <= (rp_q == PW'(DEPTH - 1)) ? '0 : rp_q + 1'b1;
      end
      cnt_q <= cnt_q + CW'(push) - CW'(load);
    end
  end

  // output stage so the drain side sees flops only
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ov_q <= 1'b0;
      od_q <= '0;
    end else if (ce) begin
      if (load) begin
        ov_q <= 1'b1;
        od_q <= mem_q[rp_q];
      end else if (out_ready) begin
        ov_q <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// ### hw/hmp_port.sv
/*
  host memory port: asynchronous strobe handshake from an external host
  into program and data memory, plus the overlay control register.
  assumes memory answers reads with mem_rd_valid some cycles after
  mem_rd_req, and drains writes through the valid/ready pair.
*/
// Summary of operation
// [R1] host starts a write only with ack low
// [R2] write start raises ack
// [R3] ack falls at least 1.5 clocks later
// [R4] long write data captured at write end
// [R5] short write accepted, committed after end
// [R6] host starts a read only with ack low
// [R7] read start raises ack until data ready
// [R8] long read: new data before ack low
// [R9] read start drives previous data
// [R10] previous data held longer for data/first half
// [R11] read end releases the bus
// [R12] normal short read only without short-read-only
// [R13] bit 14 of overlay enables short-read-only
// [R14] core or host may write overlay
// [R15] short-read-only keeps previous data throughout
// [R16] host holds read after ack low
// [R17] host latches address before access
// [R18] strobes synchronised before use
`default_nettype none
`timescale 1ns/100ps
module hmp_port #(
  parameter int FIFO_DEPTH = 16
) (
  input wire logic core_clk, // core clock
  input wire logic rst_n, // async reset, active low
  input wire logic ce, // clock enable, freezes all state
  input wire logic port_select_n, // host select strobe
  input wire logic port_write_strobe_n, // host write strobe
  input wire logic port_read_strobe_n, // host read strobe
  input wire logic port_address_latch, // host address latch
  input wire logic [15:0] bus_in, // address/data bus level
  output logic [15:0] bus_out, // address/data bus drive value
  output logic bus_oe, // high while driving the bus
  output logic port_acknowledge_n, // port acknowledge
  output logic mem_wr_valid, // write word pending
  input wire logic mem_wr_ready, // memory takes write word
  output hmp_pkg::hmp_wr_t mem_wr, // write word
  output logic mem_rd_req, // read request pulse
  output logic mem_rd_pm, // read targets program memory
  output logic [14:0] mem_rd_addr, // read address
  input wire logic mem_rd_valid, // read data pulse
  input wire logic [23:0] mem_rd_data, // read data
  input wire logic core_ovl_we, // core writes overlay
  input wire logic [15:0] core_ovl_wdata, // core overlay value
  output logic [15:0] ovl_value // overlay register
);
  // -----------------------------------------------------------------
  // helpers
  // -----------------------------------------------------------------
  function automatic logic elapsed(input logic [hmp_pkg::CNT_W-1:0] cnt, input int cyc);
    elapsed = ({30'h0, cnt} >= 32'(cyc - 1));
  endfunction

  hmp_pkg::hmp_pins_t pin_meta_q;
  hmp_pkg::hmp_pins_t pin_s_q;
  hmp_pkg::hmp_state_t st_q;
  logic [hmp_pkg::CNT_W-1:0] cnt_q;
  logic ack_n_q;
  logic [15:0] bus_out_q;
  logic oe_q;
  logic [15:0] wdata_q;
  logic [14:0] addr_q;
  logic dm_q;
  logic half_q;
  logic [15:0] pm_hi_q;
  logic [7:0] pm_lo_q;
  logic [15:0] prev_q;
  logic [15:0] new_q;
  logic fetched_q;
  logic shown_q;
  logic req_pend_q;
  logic rd_req_q;
  logic rd_pm_q;
  logic [14:0] rd_addr_q;
  logic [15:0] ovl_q;

  logic sel;
  logic wr_act;
  logic rd_act;
  logic latch;
  logic srom;
  logic ovl_hit;
  logic pm2;
  logic start_wr;
  logic start_rd;
  logic wr_ack_early;
  logic wr_commit;
  logic rd_fetch_go;
  logic rd_show;
  logic rd_finish;
  logic rd_end;
  logic fifo_in_valid;
  logic fifo_in_ready;
  logic fifo_empty;
  hmp_pkg::hmp_wr_t fifo_in;

  // -----------------------------------------------------------------
  // pin synchroniser
  // -----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_meta_q <= '{sel_n: 1'b1, wr_n: 1'b1, rd_n: 1'b1, al: 1'b0, bus: 16'h0000};
      pin_s_q <= '{sel_n: 1'b1, wr_n: 1'b1, rd_n: 1'b1, al: 1'b0, bus: 16'h0000};
    end else if (ce) begin
      pin_meta_q <= '{sel_n: port_select_n, wr_n: port_write_strobe_n, // [R18]
                      rd_n: port_read_strobe_n, al: port_address_latch, bus: bus_in};
      pin_s_q <= pin_meta_q; // [R18]
    end
  end

  // -----------------------------------------------------------------
  // access decode
  // -----------------------------------------------------------------
  assign sel = !pin_s_q.sel_n;
  assign wr_act = sel && !pin_s_q.wr_n;
  assign rd_act = sel && !pin_s_q.rd_n;
  assign latch = sel && pin_s_q.al;
  assign srom = ovl_q[hmp_pkg::OVL_SROM_BIT]; // [R13]
  assign ovl_hit = dm_q && (addr_q == hmp_pkg::OVL_ADDR);
  assign pm2 = !dm_q && half_q;

  always_comb begin
    // starts are only taken in idle, where ack is low
    start_wr = (st_q == hmp_pkg::ST_IDLE) && !latch && wr_act; // [R1] [R17]
    start_rd = (st_q == hmp_pkg::ST_IDLE) && !latch && !wr_act && rd_act; // [R6] [R17]
    wr_ack_early = (st_q == hmp_pkg::ST_WRITE) && wr_act && ack_n_q && fifo_in_ready
                   && elapsed(cnt_q, hmp_pkg::ACK_LOW_MIN_CYC); // [R3] [R4]
    wr_commit = (st_q == hmp_pkg::ST_WDONE) && fifo_in_ready
                && elapsed(cnt_q, hmp_pkg::ACK_LOW_MIN_CYC); // [R3] [R5]
    rd_fetch_go = ((st_q == hmp_pkg::ST_READ) || (st_q == hmp_pkg::ST_RFIN)) && !fetched_q
                  && !req_pend_q && fifo_empty
                  && elapsed(cnt_q, pm2 ? hmp_pkg::PREV_HOLD_PM2_CK : hmp_pkg::PREV_HOLD_DM_PM1_CK); // [R10]
    rd_show = (st_q == hmp_pkg::ST_READ) && rd_act && fetched_q && ack_n_q && !srom && !shown_q; // [R8] [R12]
    rd_finish = fetched_q && ack_n_q && (((st_q == hmp_pkg::ST_READ) && rd_act && (srom || shown_q))
                || (st_q == hmp_pkg::ST_RFIN)); // [R8] [R15]
    rd_end = (st_q == hmp_pkg::ST_READ) && !rd_act;
  end

  // -----------------------------------------------------------------
  // sequencer
  // -----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= hmp_pkg::ST_IDLE;
    end else if (ce) begin
      case (st_q)
        hmp_pkg::ST_IDLE: begin
          if (start_wr) begin
            st_q <= hmp_pkg::ST_WRITE;
          end else if (start_rd) begin
            st_q <= hmp_pkg::ST_READ;
          end
        end
        hmp_pkg::ST_WRITE: begin
          if (!wr_act) begin
            st_q <= hmp_pkg::ST_WDONE;
          end
        end
        hmp_pkg::ST_WDONE: begin
          if (wr_commit) begin
            st_q <= hmp_pkg::ST_IDLE;
          end
        end
        hmp_pkg::ST_READ: begin
          if (rd_end) begin
            st_q <= ack_n_q ? hmp_pkg::ST_RFIN : hmp_pkg::ST_IDLE; // [R12]
          end
        end
        hmp_pkg::ST_RFIN: begin
          if (rd_finish) begin
            st_q <= hmp_pkg::ST_IDLE;
          end
        end
        default: begin
          st_q <= hmp_pkg::ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
    end else if (ce) begin
      if (start_wr || start_rd) begin
        cnt_q <= '0;
      end else if (cnt_q != '1) begin
        cnt_q <= cnt_q + 1'b1;
      end
    end
  end

  // -----------------------------------------------------------------
  // acknowledge
  // -----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_n_q <= 1'b0;
    end else if (ce) begin
      if (start_wr || start_rd) begin
        ack_n_q <= 1'b1; // [R2] [R7]
      end else if (wr_ack_early || wr_commit || rd_finish) begin
        ack_n_q <= 1'b0; // [R3] [R7]
      end
    end
  end

  // -----------------------------------------------------------------
  // bus drive
  // -----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      oe_q <= 1'b0;
      bus_out_q <= hmp_pkg::BUS_RESET;
    end else if (ce) begin
      if (start_rd) begin
        oe_q <= 1'b1; // [R9]
        bus_out_q <= prev_q; // [R9]
      end else if (rd_end) begin
        oe_q <= 1'b0; // [R11]
      end else if (rd_show) begin
        bus_out_q <= new_q; // [R8]
      end
    end
  end

  // -----------------------------------------------------------------
  // address, halves and write data
  // -----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      addr_q <= '0;
      dm_q <= 1'b0;
      half_q <= 1'b0;
      wdata_q <= '0;
      pm_hi_q <= '0;
      prev_q <= hmp_pkg::BUS_RESET;
    end else if (ce) begin
      if ((st_q == hmp_pkg::ST_IDLE) && latch) begin
        addr_q <= pin_s_q.bus[hmp_pkg::ADDR_W-1:0];
        dm_q <= pin_s_q.bus[hmp_pkg::DM_SEL_BIT];
        half_q <= 1'b0;
      end else if (wr_commit || rd_finish) begin
        // program words take two halves, address steps after the second
        half_q <= !dm_q && !half_q; // [R10]
        if (dm_q || half_q) begin
          addr_q <= addr_q + 1'b1;
        end
      end
      if ((st_q == hmp_pkg::ST_WRITE) && wr_act) begin
        wdata_q <= pin_s_q.bus; // [R4] [R5]
      end
      if (wr_commit && !dm_q && !half_q) begin
        pm_hi_q <= wdata_q;
      end
      if (rd_finish) begin
        prev_q <= new_q;
      end
    end
  end

  // -----------------------------------------------------------------
  // read fetch
  // -----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      fetched_q <= 1'b0;
      shown_q <= 1'b0;
      req_pend_q <= 1'b0;
      rd_req_q <= 1'b0;
      rd_pm_q <= 1'b0;
      rd_addr_q <= '0;
      new_q <= '0;
      pm_lo_q <= '0;
    end else if (ce) begin
      rd_req_q <= 1'b0;
      if (start_rd) begin
        fetched_q <= 1'b0;
        shown_q <= 1'b0;
      end else if (rd_fetch_go) begin
        if (pm2) begin
          new_q <= {8'h00, pm_lo_q}; // [R10]
          fetched_q <= 1'b1;
        end else if (ovl_hit) begin
          new_q <= ovl_q;
          fetched_q <= 1'b1;
        end else begin
          rd_req_q <= 1'b1;
          req_pend_q <= 1'b1;
          rd_pm_q <= !dm_q;
          rd_addr_q <= addr_q;
        end
      end else if (req_pend_q && mem_rd_valid) begin
        req_pend_q <= 1'b0;
        fetched_q <= 1'b1;
        new_q <= rd_pm_q ? mem_rd_data[hmp_pkg::PM_W-1:hmp_pkg::PM_LO_W] : mem_rd_data[15:0];
        pm_lo_q <= mem_rd_data[hmp_pkg::PM_LO_W-1:0];
      end
      if (rd_show) begin
        shown_q <= 1'b1;
      end
    end
  end

  // -----------------------------------------------------------------
  // overlay register
  // -----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ovl_q <= hmp_pkg::OVL_RESET; // [R13]
    end else if (ce) begin
      if (wr_commit && ovl_hit) begin
        ovl_q <= wdata_q; // [R14]
      end else if (core_ovl_we) begin
        ovl_q <= core_ovl_wdata; // [R14]
      end
    end
  end

  // -----------------------------------------------------------------
  // write fifo
  // -----------------------------------------------------------------
  assign fifo_in_valid = wr_commit && (dm_q ? !ovl_hit : half_q); // [R5]
  assign fifo_in = '{pm: !dm_q, addr: addr_q,
                     data: dm_q ? {8'h00, wdata_q} : {pm_hi_q, wdata_q[hmp_pkg::PM_LO_W-1:0]}};

  hmp_fifo #(
    .WIDTH(hmp_pkg::WR_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .ce(ce),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data(fifo_in),
    .out_valid(mem_wr_valid),
    .out_ready(mem_wr_ready),
    .out_data(mem_wr),
    .empty(fifo_empty)
  );

  assign bus_out = bus_out_q;
  assign bus_oe = oe_q;
  assign port_acknowledge_n = ack_n_q;
  assign mem_rd_req = rd_req_q;
  assign mem_rd_pm = rd_pm_q;
  assign mem_rd_addr = rd_addr_q;
  assign ovl_value = ovl_q;
endmodule
`default_nettype wire

// ### verification/hmp_port_checker.sv
/*
  concurrent checks of hmp_port, bound to its ports.
  assumes one core clock and pins that change only between edges.
*/
`timescale 1ns/100ps
`default_nettype none
module hmp_port_checker #(
  parameter int FIFO_DEPTH = 16
) (
  input wire logic core_clk, // core clock
  input wire logic rst_n, // reset, active low
  input wire logic port_select_n, // select
  input wire logic port_write_strobe_n, // write strobe
  input wire logic port_read_strobe_n, // read strobe
  input wire logic port_address_latch, // address latch
  input wire logic [15:0] bus_out, // bus drive value
  input wire logic bus_oe, // bus drive enable
  input wire logic port_acknowledge_n, // acknowledge
  input wire logic mem_wr_valid, // write pending
  input wire logic mem_wr_ready, // write taken
  input wire hmp_pkg::hmp_wr_t mem_wr, // write word
  input wire logic mem_rd_req, // read request
  input wire logic mem_rd_valid, // read data pulse
  input wire logic core_ovl_we, // core overlay write
  input wire logic [15:0] core_ovl_wdata, // core overlay value
  input wire logic [15:0] ovl_value // overlay register
);
  // -----------------------------------------------------------------
  // properties
  // -----------------------------------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  a_wr_ack_rise: assert property (
    $fell(port_write_strobe_n) && !port_select_n && !port_address_latch && !port_acknowledge_n
    |-> ##3 port_acknowledge_n) else $error("ack not raised after write start");
  a_rd_ack_rise: assert property (
    $fell(port_read_strobe_n) && !port_select_n && !port_acknowledge_n
    |-> ##3 ($rose(bus_oe) && port_acknowledge_n)) else $error("read start not answered");
  a_ack_min_high: assert property (
    $rose(port_acknowledge_n) |-> port_acknowledge_n [*2]) else $error("ack low too early");
  a_rd_bus_release: assert property (
    (port_read_strobe_n || port_select_n) [*6] |-> !bus_oe) else $error("bus still driven after read");
  a_sro_keep_prev: assert property (
    bus_oe && $past(bus_oe) && ovl_value[14] |-> $stable(bus_out)) else $error("bus changed in short-read-only");
  a_prev_hold: assert property (
    mem_rd_req && bus_oe |-> $past(bus_oe, 2) && $stable(bus_out)) else $error("previous data hold too short");
  a_fetch_ack: assert property (
    mem_rd_valid && bus_oe |-> port_acknowledge_n ##1 port_acknowledge_n) else $error("ack low before data");
  a_new_before_ack: assert property (
    $fell(port_acknowledge_n) && bus_oe && !ovl_value[14] |-> $stable(bus_out)) else $error("data late for ack");
  a_wr_word_hold: assert property (
    mem_wr_valid && !mem_wr_ready |=> mem_wr_valid && $stable(mem_wr)) else $error("write word dropped");
  a_core_ovl: assert property (
    core_ovl_we && port_select_n && $past(port_select_n, 8) |=> ovl_value == $past(core_ovl_wdata))
    else $error("core overlay write lost");
  a_reset_values: assert property (
    !$past(rst_n) |-> ovl_value == hmp_pkg::OVL_RESET && !bus_oe && !port_acknowledge_n)
    else $error("bad values after reset");
  c_sro_read: cover property (bus_oe && ovl_value[14]);
  c_wr_stall: cover property (mem_wr_valid && !mem_wr_ready);
  c_fetch: cover property (mem_rd_valid && bus_oe);
endmodule
bind hmp_port hmp_port_checker #(.FIFO_DEPTH(FIFO_DEPTH)) hmp_port_checker_i (
  .core_clk(core_clk), .rst_n(rst_n), .port_select_n(port_select_n), .port_write_strobe_n(port_write_strobe_n),
  .port_read_strobe_n(port_read_strobe_n), .port_address_latch(port_address_latch), .bus_out(bus_out),
  .bus_oe(bus_oe), .port_acknowledge_n(port_acknowledge_n), .mem_wr_valid(mem_wr_valid),
  .mem_wr_ready(mem_wr_ready), .mem_wr(mem_wr), .mem_rd_req(mem_rd_req), .mem_rd_valid(mem_rd_valid),
  .core_ovl_we(core_ovl_we), .core_ovl_wdata(core_ovl_wdata), .ovl_value(ovl_value)
);
`default_nettype wire

// ### verification/hmp_host_model.sv
/*
  host model driving the select, strobe, latch pins and the shared bus.
  assumes the bench resolves the bus from bus_oe and calls these tasks.
*/
`timescale 1ns/100ps
`default_nettype none
module hmp_host_model (
  input wire logic core_clk, // core clock
  input wire logic port_acknowledge_n, // device acknowledge
  input wire logic [15:0] bus_out, // device bus value
  output logic port_select_n, // select
  output logic port_write_strobe_n, // write strobe
  output logic port_read_strobe_n, // read strobe
  output logic port_address_latch, // address latch
  output logic [15:0] host_bus // host value, junk when released
);
  // -----------------------------------------------------------------
  // pin sequences
  // -----------------------------------------------------------------
  logic drive = 1'b0;
  logic [15:0] data_q = 16'h0000;
  logic [15:0] junk = 16'h5aa5;
  int stalls = 0;
  assign host_bus = drive ? data_q : junk;
  initial begin
    port_select_n = 1'b1;
    port_write_strobe_n = 1'b1;
    port_read_strobe_n = 1'b1;
    port_address_latch = 1'b0;
  end
  // released bus keeps changing
  always @(negedge core_clk) junk <= ~junk;
  task automatic wait_ack(input logic lvl);
    int n;
    n = 0;
    while (port_acknowledge_n !== lvl && n < 80) begin
      @(negedge core_clk);
      n++;
    end
    if (n == 80) stalls++;
  endtask
  task automatic finish_access;
    @(negedge core_clk);
    port_select_n = 1'b1;
    port_write_strobe_n = 1'b1;
    port_read_strobe_n = 1'b1;
    port_address_latch = 1'b0;
    @(negedge core_clk);
    drive = 1'b0;
    repeat (6) @(negedge core_clk);
  endtask
  task automatic latch(input logic [15:0] a);
    wait_ack(1'b0);
    @(negedge core_clk);
    data_q = a;
    drive = 1'b1;
    port_select_n = 1'b0;
    port_address_latch = 1'b1;
    repeat (2) @(negedge core_clk);
    finish_access();
  endtask
  task automatic write(input logic [15:0] d, input logic short_wr);
    wait_ack(1'b0);
    @(negedge core_clk);
    data_q = d;
    drive = 1'b1;
    port_select_n = 1'b0;
    port_write_strobe_n = 1'b0;
    wait_ack(1'b1);
    if (short_wr) begin
      @(negedge core_clk);
      port_write_strobe_n = 1'b1;
    end
    wait_ack(1'b0);
    finish_access();
  endtask
  task automatic read(output logic [15:0] first, output logic [15:0] last);
    wait_ack(1'b0);
    @(negedge core_clk);
    port_select_n = 1'b0;
    port_read_strobe_n = 1'b0;
    wait_ack(1'b1);
    first = bus_out;
    wait_ack(1'b0);
    last = bus_out;
    finish_access();
  endtask
endmodule
`default_nettype wire

// ### verification/hmp_port_tb.sv
/*
  self-checking bench of hmp_port with a reference model of both memories.
  assumes the host model drives the pins and this bench answers memory.
*/
`timescale 1ns/100ps
`default_nettype none
module hmp_port_tb;
  // -----------------------------------------------------------------
  // design, host and memory
  // -----------------------------------------------------------------
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic sel_n, wr_n, rd_n, al, bus_oe, ack_n, mem_wr_valid, mem_rd_req, mem_rd_pm;
  logic mem_wr_ready = 1'b1, mem_rd_valid = 1'b0, core_ovl_we = 1'b0, stall = 1'b0, cur_dm, half;
  logic [15:0] host_bus, bus_w, bus_out, ovl_value, hi;
  logic [15:0] core_ovl_wdata = 16'h0000, prev = hmp_pkg::BUS_RESET, ovl_m = hmp_pkg::OVL_RESET;
  logic [14:0] mem_rd_addr;
  logic [23:0] mem_rd_data = 24'h0;
  logic [23:0] mem [0:255];
  logic [23:0] dm_m [int];
  logic [23:0] pm_m [int];
  logic [7:0] rd_key;
  hmp_pkg::hmp_wr_t mem_wr;
  int rd_wait = -1, lat = 0, fail_count = 0, checked = 0, cycles = 0, cur_a;
  always #50 core_clk = ~core_clk;
  assign bus_w = bus_oe ? bus_out : host_bus;
  hmp_port #(.FIFO_DEPTH(16)) hmp_port_i (
    .core_clk(core_clk), .rst_n(rst_n), .ce(1'b1), .port_select_n(sel_n), .port_write_strobe_n(wr_n),
    .port_read_strobe_n(rd_n), .port_address_latch(al), .bus_in(bus_w), .bus_out(bus_out), .bus_oe(bus_oe),
    .port_acknowledge_n(ack_n), .mem_wr_valid(mem_wr_valid), .mem_wr_ready(mem_wr_ready), .mem_wr(mem_wr),
    .mem_rd_req(mem_rd_req), .mem_rd_pm(mem_rd_pm), .mem_rd_addr(mem_rd_addr), .mem_rd_valid(mem_rd_valid),
    .mem_rd_data(mem_rd_data), .core_ovl_we(core_ovl_we), .core_ovl_wdata(core_ovl_wdata), .ovl_value(ovl_value)
  );
  hmp_host_model hmp_host_model_i (
    .core_clk(core_clk), .port_acknowledge_n(ack_n), .bus_out(bus_out), .port_select_n(sel_n),
    .port_write_strobe_n(wr_n), .port_read_strobe_n(rd_n), .port_address_latch(al), .host_bus(host_bus)
  );
  always @(posedge core_clk) begin
    cycles++;
    if (mem_wr_valid && mem_wr_ready) mem[{mem_wr.pm, mem_wr.addr[6:0]}] <= mem_wr.data;
    if (mem_rd_req) rd_key <= {mem_rd_pm, mem_rd_addr[6:0]};
    if (mem_rd_req) rd_wait <= lat;
    else if (rd_wait >= 0) rd_wait <= rd_wait - 1;
    if (cycles == 5000) begin
      fail_count++;
      stop_test();
    end
  end
  // read data is junk outside its pulse
  always @(negedge core_clk) begin
    mem_wr_ready <= !stall;
    mem_rd_valid <= rd_wait == 0;
    mem_rd_data <= rd_wait == 0 ? mem[rd_key] : ~mem_rd_data;
  end
  // -----------------------------------------------------------------
  // model and tasks
  // -----------------------------------------------------------------
  task automatic chk(input string what, input logic [23:0] seen, input logic [23:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic op_latch(input logic dm, input int a);
    hmp_host_model_i.latch({dm, a[14:0]});
    cur_dm = dm;
    cur_a = a;
    half = 1'b0;
  endtask
  task automatic op_write(input logic [15:0] v, input logic short_wr);
    hmp_host_model_i.write(v, short_wr);
    if (cur_dm && cur_a == 'h3fe7) ovl_m = v;
    else if (cur_dm) dm_m[cur_a] = {8'h00, v};
    else if (!half) hi = v;
    else pm_m[cur_a] = {hi, v[7:0]};
    if (cur_dm || half) cur_a++;
    if (!cur_dm) half = !half;
  endtask
  task automatic op_read;
    logic [15:0] f, l, e;
    if (cur_dm) e = cur_a == 'h3fe7 ? ovl_m : dm_m[cur_a][15:0];
    else e = half ? {8'h00, pm_m[cur_a][7:0]} : pm_m[cur_a][23:8];
    lat = $urandom_range(3);
    hmp_host_model_i.read(f, l);
    chk("read previous", f, prev);
    chk("read data", l, ovl_m[14] ? prev : e);
    prev = e;
    half = !half;
  endtask
  initial begin
    void'($urandom(32'h15013e5b));
    repeat (2) @(negedge core_clk);
    rst_n = 1'b1;
    @(negedge core_clk);
    chk("reset ack", ack_n, 1'b0);
    chk("reset oe", bus_oe, 1'b0);
    chk("reset overlay", ovl_value, hmp_pkg::OVL_RESET);
    $display("test reset done");
    op_latch(1'b1, 5);
    op_write(16'($urandom), 1'b0);
    op_write(16'($urandom), 1'b1);
    for (int i = 5; i < 7; i++) begin
      op_latch(1'b1, i);
      op_read();
    end
    $display("test dm done");
    op_latch(1'b0, 9);
    op_write(16'($urandom), 1'b0);
    op_write(16'($urandom), 1'b1);
    op_latch(1'b0, 9);
    op_read();
    op_read();
    $display("test pm done");
    stall <= 1'b1;
    op_latch(1'b1, 32);
    repeat (17) op_write(16'($urandom), 1'b1);
    fork
      op_write(16'($urandom), 1'b0);
      begin
        repeat (6) @(negedge core_clk);
        repeat (12) begin
          @(negedge core_clk);
          chk("ack while full", ack_n, 1'b1);
        end
        stall <= 1'b0;
      end
    join
    for (int i = 32; i < 50; i += 17) begin
      op_latch(1'b1, i);
      op_read();
    end
    $display("test fifo done");
    op_latch(1'b1, 'h3fe7);
    op_write(16'($urandom) | 16'h4000, 1'b0);
    chk("host overlay", ovl_value, ovl_m);
    for (int i = 5; i < 7; i++) begin
      op_latch(1'b1, i);
      op_read();
    end
    @(negedge core_clk);
    core_ovl_we = 1'b1;
    core_ovl_wdata = 16'($urandom) & 16'hbfff;
    @(negedge core_clk);
    core_ovl_we = 1'b0;
    ovl_m = core_ovl_wdata;
    chk("core overlay", ovl_value, ovl_m);
    op_latch(1'b1, 'h3fe7);
    op_read();
    $display("test overlay done");
    chk("host waits", hmp_host_model_i.stalls, 0);
    stop_test();
  end
endmodule
`default_nettype wire
